// file: cell_input_pkg.sv
// Package with register map, field layout and selection codes of the cell input selector
package cell_input_pkg;

   // Register byte addresses on the Wishbone bus
   localparam logic [3:0]  ADDR_INPUT_MUX_SELECT     = 4'h0;
   localparam logic [3:0]  ADDR_GATE_INPUT_ENABLE_LO = 4'h4;
   localparam int          ADDR_WIDTH                = 4;
   localparam int          DATA_WIDTH                = 32;
   localparam int          REG_WIDTH                 = 16;

   // Reset values
   localparam logic [15:0] SELECT_RESET              = 16'h0000;
   localparam logic [15:0] ENABLE_RESET              = 16'h0000;

   // Writable bits of the select register; bits 15, 11, 7 and 3 read as zero
   localparam logic [15:0] SELECT_WRITE_MASK         = 16'h7777;

   // Field positions in the select register
   localparam int          SEL_ONE_LSB               = 0;
   localparam int          SEL_TWO_LSB               = 4;
   localparam int          SEL_THREE_LSB             = 8;
   localparam int          SEL_FOUR_LSB              = 12;
   localparam int          SEL_WIDTH                 = 3;

   // Field positions in the enable register
   localparam int          GATE_A_LSB                = 0;
   localparam int          GATE_B_LSB                = 8;

   // Selection codes
   localparam logic [2:0]  CODE_000                  = 3'h0;
   localparam logic [2:0]  CODE_001                  = 3'h1;
   localparam logic [2:0]  CODE_010                  = 3'h2;
   localparam logic [2:0]  CODE_011                  = 3'h3;
   localparam logic [2:0]  CODE_100                  = 3'h4;
   localparam logic [2:0]  CODE_101                  = 3'h5;
   localparam logic [2:0]  CODE_110                  = 3'h6;
   localparam logic [2:0]  CODE_111                  = 3'h7;

   // Number of pin input synchroniser stages
   localparam int          SYNC_STAGES               = 3;

endpackage

// file: cell_select_props.sv
// Assertion checker for the logic cell input selector
`timescale 1ns/1ps
module cell_select_props
   import cell_input_pkg::*;
#(
   parameter int CELL_NUMBER = 1
)
(
   // Clock, reset and bus
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   // Sources watched
   input wire logic        timer3_match,
   input wire logic        comparator_one_out,
   input wire logic        dma1_interrupt,
   input wire logic [4:1]  uart_transmit,
   input wire logic [2:1]  spi_output,
   input wire logic [4:1]  cell_output,
   // Results
   input wire logic        gate_one_in,
   input wire logic        gate_two_in,
   input wire logic [3:0]  source_out
);
   localparam int NEIGH   = (CELL_NUMBER % 2) ? CELL_NUMBER + 1 : CELL_NUMBER - 1;
   localparam int SPI_IDX = (CELL_NUMBER % 2) ? 1 : 2;
   typedef struct packed {logic [15:0] sel_reg; logic [15:0] en_reg;} shadow_type;
   shadow_type shadow;
   shadow_type next_shadow;
   logic       take;
   logic       gate_a_exp;
   logic       gate_b_exp;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of both registers, updated at the edge that takes a write
   function automatic logic gate_of(input logic [7:0] en, input logic [3:0] s);
      gate_of = 1'b0;
      for (int k = 0; k < 4; k++)
         gate_of |= (en[2*k+1] & s[k]) | (en[2*k] & ~s[k]);
   endfunction
   assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign gate_a_exp = gate_of(shadow.en_reg[7:0], source_out);
   assign gate_b_exp = gate_of(shadow.en_reg[15:8], source_out);
   always_comb
   begin
      next_shadow = shadow;
      for (int i = 0; i < 2; i++)
      begin
         if (take && wb_we_i && wb_sel_i[i] && wb_adr_i == ADDR_INPUT_MUX_SELECT)
            next_shadow.sel_reg[8*i+:8] = wb_dat_i[8*i+:8] & SELECT_WRITE_MASK[8*i+:8];
         if (take && wb_we_i && wb_sel_i[i] && wb_adr_i == ADDR_GATE_INPUT_ENABLE_LO)
            next_shadow.en_reg[8*i+:8] = wb_dat_i[8*i+:8];
      end
   end
   // Cleared at reset like the registers
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         shadow <= '0;
      else
         shadow <= next_shadow;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mux outputs lag the select and the source by one register stage
   chk_mux_three_dma: assert property (
      $past(shadow.sel_reg[10:8]) == CODE_101 |-> source_out[2] == $past(dma1_interrupt))
      else $error("mux three lost dma one");
   chk_mux_two_tx: assert property (
      $past(shadow.sel_reg[6:4]) == CODE_011 |-> source_out[1] == $past(uart_transmit[CELL_NUMBER]))
      else $error("mux two lost uart transmit");
   chk_mux_two_comp: assert property (
      $past(shadow.sel_reg[6:4]) == CODE_010 |-> source_out[1] == $past(comparator_one_out))
      else $error("mux two lost comparator one");
   chk_mux_one_timer: assert property (
      $past(shadow.sel_reg[2:0]) == CODE_111 |-> source_out[0] == $past(timer3_match))
      else $error("mux one lost timer three");
   chk_mux_four_cell: assert property (
      $past(shadow.sel_reg[14:12]) == CODE_001 |-> source_out[3] == $past(cell_output[NEIGH]))
      else $error("mux four lost neighbour cell");
   chk_mux_three_spi: assert property (
      $past(shadow.sel_reg[10:8]) == CODE_011 |-> source_out[2] == $past(spi_output[SPI_IDX]))
      else $error("mux three lost spi output");
   chk_gate_one_or: assert property (
      gate_one_in == $past(gate_a_exp))
      else $error("gate one input wrong");
   chk_gate_two_or: assert property (
      gate_two_in == $past(gate_b_exp))
      else $error("gate two input wrong");
   chk_bus_answer_next: assert property (
      take |=> (wb_ack_o ^ wb_err_o))
      else $error("bus request not answered next cycle");
   chk_read_enable_data: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == ADDR_GATE_INPUT_ENABLE_LO
         |-> wb_dat_o == {16'h0000, shadow.en_reg})
      else $error("enable read data wrong");

   // Main scenarios
   cov_select_write: cover property (take && wb_we_i && wb_adr_i == ADDR_INPUT_MUX_SELECT);
   cov_gate_rise: cover property ($rose(gate_one_in));
   cov_bus_error: cover property (wb_err_o);
endmodule

bind logic_cell_input_select cell_select_props #(.CELL_NUMBER(CELL_NUMBER)) u_props (
   .ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
   .wb_dat_o, .wb_ack_o, .wb_err_o, .timer3_match, .comparator_one_out, .dma1_interrupt,
   .uart_transmit, .spi_output, .cell_output, .gate_one_in, .gate_two_in, .source_out);

// file: logic_cell_input_select.sv
// Input selection and gate enables of one configurable logic cell, Wishbone slave
//
// Contract
// [R1] Mux 3 routes DMA 1 interrupt on 101, UART receive on 100, SPI out on 011, comparator 2 on 010, pin C on 000.
// [R2] Mux 2 routes this instance's UART transmit line on code 011.
// [R3] Mux 2 routes comparator 1 on 010, compare modules 2/1 on 111/110, DMA 0 on 101, converter done on 100.
// [R4] Mux 1 routes timer 3 on 111, timer 2 on 110, nothing on 101, ref clock 100, RC 011, osc 001, cycle 000.
// [R5] Mux 4 code 001 takes the neighbour cell (1-2, 3-4), 100 takes UART receive by cell, 011 SPI input 1 or 2.
// [R6] Mux 3 code 011 takes SPI output 1 for cells 1/3 and 2 for 2/4; 001 takes cell 1 for cells 1/3, cell 2 for 2/4.
// [R7] Mux 2 code 011 takes UART transmit 1 to 4 by cell; 001 takes cell 2 for cells 1/3, cell 1 for 2/4.
// [R8] A set true-enable bit connects the uninverted mux output to its gate, a clear one removes it.
// [R9] A set negated-enable bit connects the inverted mux output to its gate, a clear one removes it.
// [R10] Gate 2 enables are bits 15..8, true/inverted pairs for sources 4..1, true bit above, bit 15 source 4 true.
// [R11] Gate 1 enables are bits 7..0 in the same pairing; all sixteen bits read, write and reset to zero.
// [R12] Each gate input is the OR of all enabled true or inverted sources, zero when none is enabled.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module logic_cell_input_select
   import cell_input_pkg::*;
#(
   parameter int CELL_NUMBER = 1
)
(
   // Clock and reset
   input  wire logic                                ref_clk,
   input  wire logic                                rst_b,
   // Wishbone slave
   input  wire logic                                wb_cyc_i,
   input  wire logic                                wb_stb_i,
   input  wire logic                                wb_we_i,
   input  wire logic [cell_input_pkg::ADDR_WIDTH-1:0] wb_adr_i,
   input  wire logic [cell_input_pkg::DATA_WIDTH-1:0] wb_dat_i,
   input  wire logic [3:0]                          wb_sel_i,
   output logic      [cell_input_pkg::DATA_WIDTH-1:0] wb_dat_o,
   output logic                                     wb_ack_o,
   output logic                                     wb_err_o,
   // Clock sources, same clock domain
   input  wire logic                                instruction_cycle_clock,
   input  wire logic                                osc_clock,
   input  wire logic                                internal_rc_clock,
   input  wire logic                                reference_clock_out,
   // Events from on-chip logic, same clock domain
   input  wire logic                                timer2_match,
   input  wire logic                                timer3_match,
   input  wire logic                                conversion_done,
   input  wire logic                                dma0_interrupt,
   input  wire logic                                dma1_interrupt,
   input  wire logic                                automation_timer_interrupt,
   input  wire logic                                comparator_one_out,
   input  wire logic                                comparator_two_out,
   input  wire logic                                comparator_three_out,
   input  wire logic [3:1]                          compare_output,
   // Serial lines, index by port number
   input  wire logic [4:1]                          uart_receive,
   input  wire logic [4:1]                          uart_transmit,
   input  wire logic [2:1]                          spi_input,
   input  wire logic [2:1]                          spi_output,
   // Cell outputs, index by cell number
   input  wire logic [4:1]                          cell_output,
   // Dedicated pins, asynchronous
   input  wire logic                                cell_input_pin_c,
   input  wire logic                                cell_input_pin_d,
   // Gate inputs toward the logic function
   output logic                                     gate_one_in,
   output logic                                     gate_two_in,
   // Selected sources, for observation
   output logic      [3:0]                          source_out
);

   typedef struct packed
   {
      logic [15:0] select;
      logic [15:0] enable;
      logic        ack;
      logic        err;
      logic [31:0] rdata;
      logic        gate_one;
      logic        gate_two;
   } top_state_type;

   top_state_type state;
   top_state_type next_state;

   logic [1:0] pins_clean;
   logic [7:0] cand_one;
   logic [7:0] cand_two;
   logic [7:0] cand_three;
   logic [7:0] cand_four;
   logic [3:0] chosen;
   logic       req;

   ////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge, used for every register write
   function automatic logic [15:0] merge_lanes(input logic [15:0] old_val,
                                               input logic [15:0] new_val,
                                               input logic [1:0]  lanes,
                                               input logic [15:0] mask);
      logic [15:0] result;
      result = old_val;
      if (lanes[0])
      begin
         result[7:0] = new_val[7:0];
      end
      if (lanes[1])
      begin
         result[15:8] = new_val[15:8];
      end
      return result & mask;
   endfunction

   // OR of enabled true and inverted sources for one gate's eight bits
   function automatic logic gate_combine(input logic [7:0] en, input logic [3:0] src);
      logic acc;
      acc = 1'b0;
      for (int s = 0; s < 4; s++)
      begin
         acc = acc | (en[2*s+1] & src[s]) | (en[2*s] & ~src[s]);
      end
      return acc;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pins come from outside the clock domain
   pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .raw_in    ({cell_input_pin_d, cell_input_pin_c}),
      .clean_out (pins_clean)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Candidate tables; index is the selection code
   always_comb
   begin
      // [R4] Mux 1 sources
      cand_one           = 8'h00;
      cand_one[CODE_111] = timer3_match;
      cand_one[CODE_110] = timer2_match;
      cand_one[CODE_101] = 1'b0;          // Unimplemented code reads low
      cand_one[CODE_100] = reference_clock_out;
      cand_one[CODE_011] = internal_rc_clock;
      cand_one[CODE_010] = 1'b0;
      cand_one[CODE_001] = osc_clock;
      cand_one[CODE_000] = instruction_cycle_clock;

      // [R3] Mux 2 fixed sources
      cand_two           = 8'h00;
      cand_two[CODE_111] = compare_output[2];
      cand_two[CODE_110] = compare_output[1];
      cand_two[CODE_101] = dma0_interrupt;
      cand_two[CODE_100] = conversion_done;
      cand_two[CODE_010] = comparator_one_out;
      cand_two[CODE_000] = pins_clean[1];
      // [R2] [R7] UART transmit of this cell
      cand_two[CODE_011] = uart_transmit[CELL_NUMBER];
      // [R7] Neighbour output, cells 1/3 take 2, cells 2/4 take 1
      cand_two[CODE_001] = (CELL_NUMBER % 2 == 1) ? cell_output[2] : cell_output[1];

      // [R1] Mux 3 fixed sources
      cand_three           = 8'h00;
      cand_three[CODE_111] = compare_output[3];
      cand_three[CODE_110] = compare_output[2];
      cand_three[CODE_101] = dma1_interrupt;
      cand_three[CODE_100] = uart_receive[CELL_NUMBER];
      cand_three[CODE_010] = comparator_two_out;
      cand_three[CODE_000] = pins_clean[0];
      // [R6] SPI output and cell output by cell parity
      cand_three[CODE_011] = (CELL_NUMBER % 2 == 1) ? spi_output[1] : spi_output[2];
      cand_three[CODE_001] = (CELL_NUMBER % 2 == 1) ? cell_output[1] : cell_output[2];

      // [R5] Mux 4 sources by cell
      cand_four           = 8'h00;
      cand_four[CODE_111] = compare_output[3];
      cand_four[CODE_110] = compare_output[1];
      cand_four[CODE_101] = 1'b0;
      cand_four[CODE_100] = uart_receive[CELL_NUMBER];
      cand_four[CODE_011] = (CELL_NUMBER % 2 == 1) ? spi_input[1] : spi_input[2];
      cand_four[CODE_010] = comparator_three_out;
      cand_four[CODE_001] = cell_output[((CELL_NUMBER - 1) ^ 1) + 1];
      cand_four[CODE_000] = pins_clean[1];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Four data-selection multiplexers
   source_mux u_mux_one (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .candidates (cand_one),
      .select     (state.select[SEL_ONE_LSB +: SEL_WIDTH]),
      .chosen     (chosen[0])
   );

   source_mux u_mux_two (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .candidates (cand_two),
      .select     (state.select[SEL_TWO_LSB +: SEL_WIDTH]),
      .chosen     (chosen[1])
   );

   source_mux u_mux_three (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .candidates (cand_three),
      .select     (state.select[SEL_THREE_LSB +: SEL_WIDTH]),
      .chosen     (chosen[2])
   );

   source_mux u_mux_four (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .candidates (cand_four),
      .select     (state.select[SEL_FOUR_LSB +: SEL_WIDTH]),
      .chosen     (chosen[3])
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus request is a new strobe not yet answered
   assign req = wb_cyc_i & wb_stb_i & ~state.ack & ~state.err;

   // Register file, bus answer and gate combination
   always_comb
   begin
      next_state       = state;
      next_state.ack   = 1'b0;
      next_state.err   = 1'b0;
      next_state.rdata = 32'h0000_0000;
      if (req)
      begin
         unique case (wb_adr_i)
            ADDR_INPUT_MUX_SELECT:
            begin
               next_state.ack = 1'b1;
               if (wb_we_i)
               begin
                  next_state.select = merge_lanes(state.select, wb_dat_i[15:0],
                                                  wb_sel_i[1:0], SELECT_WRITE_MASK);
               end
               next_state.rdata = {16'h0000, state.select};
            end
            ADDR_GATE_INPUT_ENABLE_LO:
            begin
               next_state.ack = 1'b1;
               // [R11] All sixteen enable bits writable
               if (wb_we_i)
               begin
                  next_state.enable = merge_lanes(state.enable, wb_dat_i[15:0],
                                                  wb_sel_i[1:0], 16'hffff);
               end
               next_state.rdata = {16'h0000, state.enable};
            end
            default:
            begin
               next_state.err = 1'b1;   // Unmapped address
            end
         endcase
      end

      // [R8] [R9] [R12] Gate 1 from bits 7..0
      next_state.gate_one = gate_combine(state.enable[GATE_A_LSB +: 8], chosen);
      // [R10] [R12] Gate 2 from bits 15..8
      next_state.gate_two = gate_combine(state.enable[GATE_B_LSB +: 8], chosen);
   end

   // [R11] Enables clear to zero at reset
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state        <= '0;
         state.select <= SELECT_RESET;
         state.enable <= ENABLE_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign wb_dat_o    = state.rdata;
   assign wb_ack_o    = state.ack;
   assign wb_err_o    = state.err;
   assign gate_one_in = state.gate_one;
   assign gate_two_in = state.gate_two;
   assign source_out  = chosen;

endmodule

// file: logic_cell_input_select_test.sv
// Self-checking testbench for the logic cell input selector
`timescale 1ns/1ps
module logic_cell_input_select_test;
   import cell_input_pkg::*;
   localparam int CELL = 3;
   logic        ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
   logic [3:0]  wb_adr_i, wb_sel_i, source_out;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic        gate_one_in, gate_two_in, instruction_cycle_clock, osc_clock;
   logic        internal_rc_clock, reference_clock_out, timer2_match, timer3_match;
   logic        conversion_done, dma0_interrupt, dma1_interrupt, automation_timer_interrupt;
   logic        comparator_one_out, comparator_two_out, comparator_three_out;
   logic        cell_input_pin_c, cell_input_pin_d;
   logic [3:1]  compare_output;
   logic [4:1]  uart_receive, uart_transmit, cell_output;
   logic [2:1]  spi_input, spi_output;
   logic [34:0] vec;
   logic [3:0]  p;
   int          n_mismatch, cmp_count;
   // Bit 34 drives nothing: unused codes must read zero
   int tab_mux[32]  = '{0,0,0,0,0,0,0, 1,1,1,1,1,1,1, 2,2,2,2,2,2, 3,3,3, 0,1,2,2,3,3,3,3,3};
   int tab_code[32] = '{7,6,5,4,3,1,0, 7,6,5,4,3,2,1, 5,4,3,2,1,0, 1,4,3, 2,0,7,6,7,6,5,2,0};
   int tab_bit[32]  = '{5,4,34,3,2,1,0, 14,13,7,6,22,10,29, 8,18,26,11,28,32, 31,18,24,
                        34,33,15,14,15,13,34,12,33};
   logic [15:0] en_list[11] = '{16'h0000, 16'h0002, 16'h0001, 16'h0080, 16'h0040,
                                16'h8000, 16'h4000, 16'h0200, 16'h0100, 16'h00aa, 16'h5500};

   periph_sources u_src (.drive_vec(vec[33:0]), .*);
   logic_cell_input_select #(.CELL_NUMBER(CELL)) u_dut (.*);

   always #2.5 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Closing report, also reached when a bus wait runs out
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask
   // Classic cycle: request held until ack or err is sampled, then one idle cycle
   task automatic wb_cycle(input logic [3:0] a, input logic w, input logic [15:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= {16'h0000, d};
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      e = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge ref_clk);
      if (n >= 20)
      begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   // Gate value: odd bit true, even bit inverted per source
   function automatic logic gexp(input logic [7:0] en, input logic [3:0] s);
      gexp = 1'b0;
      for (int k = 0; k < 4; k++)
         gexp |= (en[2*k+1] & s[k]) | (en[2*k] & ~s[k]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'h3;
      vec = '0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      wb_cycle(ADDR_INPUT_MUX_SELECT, 1'b0, 16'h0000);
      cmp_word(q, 32'h00000000);
      wb_cycle(ADDR_GATE_INPUT_ENABLE_LO, 1'b0, 16'h0000);
      cmp_word(q, 32'h00000000);
      wb_cycle(ADDR_INPUT_MUX_SELECT, 1'b1, 16'hffff);
      wb_cycle(ADDR_INPUT_MUX_SELECT, 1'b0, 16'h0000);
      cmp_word(q, 32'h00007777);
      wb_cycle(ADDR_GATE_INPUT_ENABLE_LO, 1'b1, 16'ha5c3);
      wb_cycle(ADDR_GATE_INPUT_ENABLE_LO, 1'b0, 16'h0000);
      cmp_word(q, 32'h0000a5c3);
      // Unmapped place is refused and writes nothing
      wb_cycle(4'h8, 1'b1, 16'hffff);
      cmp_bit(e, 1'b1);
      wb_cycle(ADDR_GATE_INPUT_ENABLE_LO, 1'b0, 16'h0000);
      cmp_word(q, 32'h0000a5c3);
      $display("test registers done");
      // Each code: source alone high, then every other source high
      for (int i = 0; i < 32; i++)
      begin
         wb_cycle(ADDR_INPUT_MUX_SELECT, 1'b1, 16'(tab_code[i] << (4 * tab_mux[i])));
         vec <= 35'h1 << tab_bit[i];
         repeat (8) @(posedge ref_clk);
         cmp_bit(source_out[tab_mux[i]], tab_bit[i] != 34);
         vec <= ~(35'h1 << tab_bit[i]);
         repeat (8) @(posedge ref_clk);
         cmp_bit(source_out[tab_mux[i]], 1'b0);
      end
      $display("test multiplexers done");
      // Sources: timer 3, comparator 1, DMA 1, neighbour cell 4
      wb_cycle(ADDR_INPUT_MUX_SELECT, 1'b1, 16'h1527);
      for (int j = 0; j < 11; j++)
      begin
         wb_cycle(ADDR_GATE_INPUT_ENABLE_LO, 1'b1, en_list[j]);
         for (int m = 0; m < 16; m++)
         begin
            p = 4'(m);
            vec <= {3'h0, p[3], 20'h0, p[1], 1'b0, p[2], 2'h0, p[0], 5'h0};
            repeat (4) @(posedge ref_clk);
            cmp_word({28'h0, source_out}, {28'h0, p});
            cmp_bit(gate_one_in, gexp(en_list[j][7:0], p));
            cmp_bit(gate_two_in, gexp(en_list[j][15:8], p));
         end
      end
      $display("test gates done");
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      wb_cycle(ADDR_GATE_INPUT_ENABLE_LO, 1'b0, 16'h0000);
      cmp_word(q, 32'h00000000);
      $display("test second reset done");
      give_verdict();
   end
endmodule

// file: periph_sources.sv
// Model of the on-chip peripherals and pins feeding the cell selector
`timescale 1ns/1ps
module periph_sources
(
   // One bit per source, bit order fixed by the bench table
   input  wire logic [33:0] drive_vec,
   // Peripheral levels
   output logic             instruction_cycle_clock, osc_clock, internal_rc_clock,
   output logic             reference_clock_out, timer2_match, timer3_match,
   output logic             conversion_done, dma0_interrupt, dma1_interrupt,
   output logic             automation_timer_interrupt, comparator_one_out,
   output logic             comparator_two_out, comparator_three_out,
   output logic [3:1]       compare_output,
   output logic [4:1]       uart_receive, uart_transmit, cell_output,
   output logic [2:1]       spi_input, spi_output,
   output logic             cell_input_pin_c, cell_input_pin_d
);
   // Every source is a plain level; pins change freely, the design filters them
   assign {cell_input_pin_d, cell_input_pin_c, cell_output, spi_output, spi_input,
           uart_transmit, uart_receive, compare_output, comparator_three_out,
           comparator_two_out, comparator_one_out, automation_timer_interrupt,
           dma1_interrupt, dma0_interrupt, conversion_done, timer3_match, timer2_match,
           reference_clock_out, internal_rc_clock, osc_clock,
           instruction_cycle_clock} = drive_vec;
endmodule

// file: pin_sync.sv
// Three-stage synchroniser for asynchronous inputs, change taken when stages two and three agree
`timescale 1ns/1ps
module pin_sync
   import cell_input_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // Raw and filtered levels
   input  wire logic [WIDTH-1:0] raw_in,
   output logic      [WIDTH-1:0] clean_out
);

   typedef struct packed
   {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
      logic [WIDTH-1:0] third;
      logic [WIDTH-1:0] held;
   } sync_state_type;

   sync_state_type state;
   sync_state_type next_state;

   ////////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second; held value moves only on agreement
   always_comb
   begin
      next_state        = state;
      next_state.first  = raw_in;
      next_state.second = state.first;
      next_state.third  = state.second;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (state.second[i] == state.third[i])
         begin
            next_state.held[i] = state.third[i];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign clean_out = state.held;

endmodule

// file: source_mux.sv
// One data-selection multiplexer with registered output
`timescale 1ns/1ps
module source_mux
   import cell_input_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // Candidate signals, index is the selection code
   input  wire logic [7:0] candidates,
   input  wire logic [2:0] select,
   // Selected source
   output logic            chosen
);

   typedef struct packed
   {
      logic chosen;
   } mux_state_type;

   mux_state_type state;
   mux_state_type next_state;

   ////////////////////////////////////////////////////////////////////////////
   // Registering the pick keeps select changes glitch free toward the gates
   always_comb
   begin
      next_state        = state;
      next_state.chosen = candidates[select];
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign chosen = state.chosen;

endmodule
